// [src/sap_port.sv]
// Behaviour
// - Port is active while chip select low, idle while it is high.
// - Two-channel variant powers down when chip select high or not converting.
// - Result is eight bits, shifted out most significant bit first.
// - After the result, further shift clocks output zeros without limit.
// - Exchange begins on chip select falling edge, driven by the host.
// - Fixed variant enables serial output on first shift clock after select falls.
// - Two null bit periods precede the first result bit.
// - Chip select rising returns the port to idle.
// - Two-channel variant samples serial input on shift clock rising edge.
// - Serial output changes on each shift clock rising edge.
// - Leading input zeros are ignored; the first one is the start bit.
// - Exactly four request bits follow the start bit.
// - First two request bits select the multiplexer configuration.
// - Last two request bits give 2.5 clocks acquisition before conversion.
// - After the request, serial input is ignored until next select cycle.
// - Fixed variant takes no request and converts its differential pair.
// - Single-ended configurations measure the channel against ground.
// - Trailing two request bits are accepted with any value and ignored.
// - Shared wire: output driven low on fifth falling edge after start bit.
`timescale 1ns/10ps
`default_nettype none
module sap_port
  import sap_pkg::*;
#(
  parameter bit         TWO_CHANNEL = 1'b1,
  parameter logic [7:0] MUX_MAP     = MUX_MAP_DEFAULT,
  parameter int         FIFO_DEPTH_P = FIFO_DEPTH
) (
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic                   cs_n_pin,
  input  wire logic                   sclk_pin,
  input  wire logic                   din_pin,
  output logic                        dout_o,
  output logic                        dout_oe,
  input  wire logic [RESULT_BITS-1:0] conv_data,
  input  wire logic                   conv_valid,
  output logic                        conv_ready,
  output logic                        sample_start,
  output sap_mux_type                 mux_sel,
  output logic                        powered_up,
  output logic                        busy
);
  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage feeds nothing but the second
  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic       sclk_d_reg;
  logic       cs_n_d_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg   <= 3'h7;
      sync_reg   <= 3'h7;
      sclk_d_reg <= 1'h1;
      cs_n_d_reg <= 1'h1;
    end else begin
      meta_reg   <= {cs_n_pin, sclk_pin, din_pin};
      sync_reg   <= meta_reg;
      sclk_d_reg <= sync_reg[1];
      cs_n_d_reg <= sync_reg[2];
    end
  end

  logic cs_n;
  logic din;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  assign cs_n      = sync_reg[2];
  assign din       = sync_reg[0];
  assign sclk_rise = sync_reg[1] && !sclk_d_reg;
  assign sclk_fall = !sync_reg[1] && sclk_d_reg;
  assign cs_fall   = !cs_n && cs_n_d_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Result FIFO: the converter core fills it, each exchange takes at most one word
  logic [SAMPLE_W-1:0] fifo_out;
  logic                fifo_valid;
  logic                fifo_pop;

  sap_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (FIFO_DEPTH_P)
  ) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_data   ({mux_sel, conv_data}),
    .in_valid  (conv_valid),
    .in_ready  (conv_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Exchange sequencer
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HUNT,
    ST_REQ,
    ST_NULL,
    ST_DATA,
    ST_ZERO
  } sap_state_type;

  sap_state_type          state_reg;
  sap_state_type          state_next;
  logic [CNT_W-1:0]       cnt_reg;
  logic [CNT_W-1:0]       cnt_next;
  logic [REQ_BITS-1:0]    req_reg;
  logic [REQ_BITS-1:0]    req_next;
  logic [RESULT_BITS-1:0] shift_reg;
  logic [RESULT_BITS-1:0] shift_next;
  logic [CNT_W-1:0]       fall_reg;
  logic [CNT_W-1:0]       fall_next;
  logic                   dout_next;
  logic                   oe_next;
  logic                   start_next;
  sap_mux_type            mux_next;
  logic                   pwr_next;
  logic                   busy_next;

  function automatic sap_mux_type map_sel(input logic [MUX_BITS-1:0] sel);
    map_sel = sap_mux_type'(MUX_MAP[{sel, 1'b0} +: 2]);
  endfunction

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    req_next   = req_reg;
    shift_next = shift_reg;
    fall_next  = fall_reg;
    dout_next  = dout_o;
    oe_next    = dout_oe;
    start_next = 1'b0;
    mux_next   = mux_sel;
    pwr_next   = powered_up;
    busy_next  = busy;
    fifo_pop   = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (cs_fall) begin
          busy_next = 1'b1;
          pwr_next  = !TWO_CHANNEL;
          cnt_next  = CNT_ZERO;
          fall_next = CNT_ZERO;
          if (TWO_CHANNEL) begin
            state_next = ST_HUNT;
          end else begin
            mux_next   = '0;
            state_next = ST_NULL;
          end
        end
      end
      ST_HUNT: begin
        if (sclk_rise && din) begin
          pwr_next   = 1'b1;
          cnt_next   = CNT_ZERO;
          state_next = ST_REQ;
        end
      end
      ST_REQ: begin
        if (sclk_rise) begin
          req_next = {req_reg[REQ_BITS-2:0], din};
          cnt_next = cnt_reg + CNT_ONE;
          if (cnt_reg == CNT_W'(MUX_BITS - 1)) begin
            // single-ended flag means the minus side is ground
            mux_next   = map_sel({req_reg[0], din});
            start_next = 1'b1; // acquisition runs through dummy bits
          end
          if (cnt_reg == CNT_W'(REQ_BITS - 1)) begin
            cnt_next   = CNT_ZERO;
            state_next = ST_NULL;
          end
        end
        if (sclk_fall) begin
          fall_next = fall_reg + CNT_ONE;
          if (fall_reg == CNT_W'(DRIVE_FALL_NUM - 1)) begin
            dout_next = 1'b0;
            oe_next   = 1'b1;
          end
        end
      end
      ST_NULL: begin
        if (sclk_fall && TWO_CHANNEL && !dout_oe) begin
          dout_next = 1'b0;
          oe_next   = 1'b1;
        end
        if (sclk_rise) begin
          dout_next = 1'b0;
          oe_next   = 1'b1;
          cnt_next  = cnt_reg + CNT_ONE;
          if (cnt_reg == CNT_W'(NULL_BITS)) begin
            // Missing sample reads as zero rather than stalling the host clock
            shift_next = fifo_valid ? fifo_out[RESULT_BITS-1:0] : '0;
            fifo_pop   = fifo_valid;
            dout_next  = shift_next[RESULT_BITS-1];
            cnt_next   = CNT_ONE;
            state_next = ST_DATA;
          end
        end
      end
      ST_DATA: begin
        if (sclk_rise) begin
          shift_next = {shift_reg[RESULT_BITS-2:0], 1'b0};
          dout_next  = shift_next[RESULT_BITS-1];
          cnt_next   = cnt_reg + CNT_ONE;
          if (cnt_reg == CNT_W'(RESULT_BITS - 1)) begin
            pwr_next   = !TWO_CHANNEL;
            state_next = ST_ZERO;
          end
        end
      end
      ST_ZERO: begin
        if (sclk_rise) begin
          dout_next = 1'b0;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (cs_n && state_reg != ST_IDLE) begin
      state_next = ST_IDLE;
      oe_next    = 1'b0;
      dout_next  = 1'b0;
      pwr_next   = 1'b0;
      busy_next  = 1'b0;
      start_next = 1'b0;
      fifo_pop   = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg    <= ST_IDLE;
      cnt_reg      <= CNT_ZERO;
      req_reg      <= '0;
      shift_reg    <= '0;
      fall_reg     <= CNT_ZERO;
      dout_o       <= 1'b0;
      dout_oe      <= 1'b0;
      sample_start <= 1'b0;
      mux_sel      <= '0;
      powered_up   <= 1'b0;
      busy         <= 1'b0;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      req_reg      <= req_next;
      shift_reg    <= shift_next;
      fall_reg     <= fall_next;
      dout_o       <= dout_next;
      dout_oe      <= oe_next;
      sample_start <= start_next;
      mux_sel      <= mux_next;
      powered_up   <= pwr_next;
      busy         <= busy_next;
    end
  end
endmodule
`default_nettype wire

// [src/sap_pkg.sv]
package sap_pkg;

  localparam int RESULT_BITS    = 8;
  localparam int REQ_BITS       = 4;
  localparam int NULL_BITS      = 2;
  localparam int MUX_BITS       = 2;
  localparam int DUMMY_BITS     = 2;
  localparam int DRIVE_FALL_NUM = 5;
  localparam int FIFO_DEPTH     = 8;
  localparam int CNT_W          = 4;
  localparam int MUX_MSB        = 3;
  localparam int MUX_LSB        = 2;

  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;

  // Mux setting as it leaves the port: positive and negative channel choice
  typedef struct packed {
    logic       single_ended;
    logic       pos_is_b;
  } sap_mux_type;

  typedef struct packed {
    sap_mux_type                  mux;
    logic [RESULT_BITS-1:0]       data;
  } sap_sample_type;

  localparam int SAMPLE_W = $bits(sap_sample_type);

  // Default map from the two select bits to a configuration, index = bits
  localparam logic [7:0] MUX_MAP_DEFAULT = 8'hB1;

endpackage

// [src/sap_fifo.sv]
`timescale 1ns/10ps
`default_nettype none
module sap_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    wr_next;
  logic [AW-1:0]    rd_reg;
  logic [AW-1:0]    rd_next;
  logic [AW:0]      cnt_reg;
  logic [AW:0]      cnt_next;
  logic             push;
  logic             pop;
  logic             ready_next;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_comb begin
    out_valid  = (cnt_reg != '0);
    out_data   = mem[rd_reg];
    push       = in_valid && in_ready;
    pop        = out_valid && out_ready;
    wr_next    = push ? bump(wr_reg) : wr_reg;
    rd_next    = pop ? bump(rd_reg) : rd_reg;
    cnt_next   = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    // Ready taken from the next count so the port comes straight from a flop
    ready_next = (cnt_next != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_reg   <= '0;
      rd_reg   <= '0;
      cnt_reg  <= '0;
      in_ready <= 1'b1;
    end else begin
      wr_reg   <= wr_next;
      rd_reg   <= rd_next;
      cnt_reg  <= cnt_next;
      in_ready <= ready_next;
    end
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end
endmodule
`default_nettype wire

// [tb/sap_port_properties.sv]
`timescale 1ns/10ps
`default_nettype none
module sap_port_properties
  import sap_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   srst,
  input wire logic                   cs_n_pin,
  input wire logic                   sclk_pin,
  input wire logic                   din_pin,
  input wire logic                   dout_o,
  input wire logic                   dout_oe,
  input wire logic [RESULT_BITS-1:0] conv_data,
  input wire logic                   conv_valid,
  input wire logic                   conv_ready,
  input wire logic                   sample_start,
  input wire sap_mux_type            mux_sel,
  input wire logic                   powered_up,
  input wire logic                   busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////
  // Six cycles cover the pin synchronisers plus the output register
  sequence idle_s; cs_n_pin [*6]; endsequence
  sequence quiet_s; ($stable(sclk_pin) && $stable(cs_n_pin)) [*6]; endsequence
  oe_idle_a: assert property (idle_s |=> !dout_oe && !busy)
    else $error("output enabled while deselected");
  power_idle_a: assert property (idle_s |=> !powered_up)
    else $error("powered while deselected");
  dout_hold_a: assert property (quiet_s |=> $stable(dout_o))
    else $error("serial output moved without a shift clock");
  null_low_a: assert property ($rose(dout_oe) |-> !dout_o)
    else $error("output not low when enabled");
  oe_busy_a: assert property (dout_oe |-> busy)
    else $error("output enabled outside an exchange");
  power_busy_a: assert property (powered_up |-> busy)
    else $error("powered outside an exchange");
  mux_change_a: assert property ($changed(mux_sel) |-> sample_start)
    else $error("mux changed without acquisition start");
  start_pulse_a: assert property (sample_start |-> busy ##1 !sample_start)
    else $error("acquisition start not a single pulse");
endmodule
`default_nettype wire

// [tb/sap_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module sap_host_model (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic        fixed,
  input  wire logic [3:0]  req,
  input  wire logic [1:0]  lead,
  input  wire logic [2:0]  half,
  input  wire logic        dout_o,
  input  wire logic        dout_oe,
  output logic             cs_n,
  output logic             sclk,
  output logic             din,
  output logic             done,
  output logic [12:0]      word
);
  int seed = 43;
  // Clock idles low between frames; din changes only while sclk is low
  task automatic tick(input logic b, input logic cap);
    din <= b;
    repeat (half) @(posedge clk);
    if (cap) word <= {word[11:0], dout_oe ? dout_o : 1'bx};
    sclk <= 1'b1;
    repeat (half) @(posedge clk);
    sclk <= 1'b0;
  endtask
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
    done = 1'b0;
    word = 13'h0000;
    forever begin
      @(posedge clk);
      if (go) begin
        cs_n <= 1'b0;
        // Fixed variant takes no request word, so din stays low
        if (!fixed) begin
          for (int i = 0; i < lead; i++) tick(1'b0, 1'b0);
          tick(1'b1, 1'b0);
          for (int i = 3; i >= 0; i--) tick(req[i], 1'b0);
        end
        // Junk on din after the request must be ignored
        for (int i = 0; i < 14; i++) tick(fixed ? 1'b0 : 1'($random(seed)), i > 0);
        cs_n <= 1'b1;
        repeat (8) @(posedge clk);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/sap_port_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module sap_port_bench;
  import sap_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        cs_n, sclk, din, dout_o, dout_oe, go, done;
  logic        dout_fx, oe_fx, fx;
  logic        conv_valid, conv_ready, sample_start, powered_up, busy;
  logic [7:0]  conv_data;
  logic [3:0]  req;
  logic [1:0]  lead;
  logic [2:0]  half;
  logic [12:0] word;
  sap_mux_type mux_sel;
  logic [7:0]  exp_q[$];
  sap_mux_type mux_q[$];
  int          bad_count = 0;
  int          samples_checked = 0;
  int          seed = 43;
  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  sap_port u_dut (.clk(clk), .srst(srst), .cs_n_pin(cs_n), .sclk_pin(sclk),
    .din_pin(din), .dout_o(dout_o), .dout_oe(dout_oe), .conv_data(conv_data),
    .conv_valid(conv_valid), .conv_ready(conv_ready), .sample_start(sample_start),
    .mux_sel(mux_sel), .powered_up(powered_up), .busy(busy));
  // Fixed variant shares the pins; the host listens to it only in fixed frames
  sap_port #(.TWO_CHANNEL(1'b0)) u_dut_fixed (.clk(clk), .srst(srst), .cs_n_pin(cs_n),
    .sclk_pin(sclk), .din_pin(din), .dout_o(dout_fx), .dout_oe(oe_fx),
    .conv_data(conv_data), .conv_valid(conv_valid), .conv_ready(), .sample_start(),
    .mux_sel(), .powered_up(), .busy());
  sap_host_model u_host (.clk(clk), .go(go), .fixed(fx), .req(req), .lead(lead), .half(half),
    .dout_o(fx ? dout_fx : dout_o), .dout_oe(fx ? oe_fx : dout_oe), .cs_n(cs_n), .sclk(sclk),
    .din(din), .done(done), .word(word));
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic push(input logic [7:0] d);
    @(posedge clk);
    conv_data  <= d;
    conv_valid <= 1'b1;
    exp_q.push_back(d);
    @(negedge clk);
    while (conv_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    conv_valid <= 1'b0;
  endtask
  // Half period 4..7 cycles: both prompt and slow hosts
  task automatic xfer(input logic [3:0] r);
    @(posedge clk);
    req  <= r;
    lead <= 2'($random(seed));
    half <= 3'(4 + ($random(seed) & 3));
    go   <= 1'b1;
    if (!fx) mux_q.push_back(sap_mux_type'(MUX_MAP_DEFAULT[2*r[3:2] +: 2]));
    @(posedge clk);
    go <= 1'b0;
    wait (done);
    @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (done) check({3'h0, word}, {5'h00, exp_q.pop_front(), 3'h0});
    if (sample_start) check(16'(mux_sel), 16'(mux_q.pop_front()));
    if (sample_start) check(16'({busy, powered_up}), 16'h0003);
  end
  initial begin
    #100000;
    bad_count++;
    conclude();
  end
  initial begin
    go = 1'b0;
    fx = 1'b0;
    req = 4'h0;
    lead = 2'h0;
    half = 3'h4;
    conv_valid = 1'b0;
    conv_data = 8'h00;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(negedge clk);
    check({busy, powered_up, dout_oe, dout_o}, 16'h0000);
    // Empty buffer yields a zero result
    exp_q.push_back(8'h00);
    xfer(4'hB);
    repeat (FIFO_DEPTH) push(8'($random(seed)));
    @(posedge clk);
    conv_data  <= 8'hA5;
    conv_valid <= 1'b1;
    repeat (3) @(negedge clk);
    check(16'(conv_ready), 16'h0000);
    @(posedge clk);
    conv_valid <= 1'b0;
    for (int i = 0; i < FIFO_DEPTH; i++) xfer({2'(i), 2'($random(seed))});
    // Fixed variant: no request, output enabled by the first shift clock
    @(posedge clk);
    fx <= 1'b1;
    repeat (2) begin
      push(8'($random(seed)));
      xfer(4'h0);
    end
    repeat (20) @(posedge clk);
    conclude();
  end
endmodule
bind sap_port sap_port_properties u_props (.clk(clk), .srst(srst), .cs_n_pin(cs_n_pin),
  .sclk_pin(sclk_pin), .din_pin(din_pin), .dout_o(dout_o), .dout_oe(dout_oe),
  .conv_data(conv_data), .conv_valid(conv_valid), .conv_ready(conv_ready),
  .sample_start(sample_start), .mux_sel(mux_sel), .powered_up(powered_up), .busy(busy));
`default_nettype wire
